// *** core/atsc_pkg.sv ***
// Behaviour
// RQ1 - Sample period is set by spacing of sample pulses; one sample per pulse.
// RQ2 - Conversion period is set by spacing of conversion pulses; one conversion each.
// RQ3 - Posttrigger mode preloads posttrigger count, decrements per sample until done.
// RQ4 - Start trigger accepted from external pulse or software command.
// RQ5 - Software start drives a pulse on start-trigger output when acquisition begins.
// RQ6 - Pretrigger mode loads pretrigger count at start, decrements per sample.
// RQ7 - Pretrigger count exhausted reloads counter with posttrigger count.
// RQ8 - Reference trigger ignored before pretrigger samples are all acquired.
// RQ9 - Accepted reference trigger lets counter decrement through posttrigger samples.
// RQ10 - Sample pulses ignored when idle or while paused.
// RQ11 - Internal sample pacing starts on start trigger, first pulse after delay, default two.
// RQ12 - Counter zero in final phase ends acquisition, blocks samples, flags done.
package atsc_pkg;
  localparam int CNT_W            = 24;
  localparam int DIV_W            = 16;
  localparam logic [7:0] FIRST_DELAY_DEF = 8'h02;
  localparam logic [DIV_W-1:0] DIV_DEF   = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 24'h000000;
  localparam logic [DIV_W-1:0] DIV_ZERO  = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DLY  = 3'b001,
    ST_PRE  = 3'b010,
    ST_ARM  = 3'b011,
    ST_POST = 3'b100
  } atsc_state_t;
endpackage

// *** core/atsc_acq_trigger_sample_counter.sv ***
`timescale 1ns/10ps
module atsc_acq_trigger_sample_counter #(
  parameter int CNT_W = atsc_pkg::CNT_W,
  parameter int DIV_W = atsc_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             NRST,
  // Configuration
  input  wire logic             PRETRIG_MODE,
  input  wire logic             SW_START_SEL,
  input  wire logic             INT_SAMPLE_SEL,
  input  wire logic [CNT_W-1:0] PRE_COUNT,
  input  wire logic [CNT_W-1:0] POST_COUNT,
  input  wire logic [DIV_W-1:0] SAMPLE_DIV,
  input  wire logic [7:0]       FIRST_DELAY,
  // Triggers and pacing
  input  wire logic             TIMEBASE_TICK,
  input  wire logic             SW_START,
  input  wire logic             EXT_START,
  input  wire logic             ACQ_REFERENCE_TRIGGER,
  input  wire logic             PAUSE,
  input  wire logic             ABORT,
  input  wire logic             EXT_SAMPLE_PULSE,
  input  wire logic             CONVERSION_PULSE,
  // Status and outputs
  output logic                  ACQ_START_TRIGGER,
  output logic                  SAMPLE_PULSE,
  output logic                  CONVERT_TAKEN,
  output logic                  ACQ_BUSY,
  output logic                  ACQ_DONE,
  output logic                  REF_ACCEPTED,
  output logic [CNT_W-1:0]      SAMPLE_COUNT
);
  atsc_pkg::atsc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [7:0]       dly_reg, dly_next;
  logic             stp_reg, stp_next;
  logic             smp_reg, smp_next;
  logic             cnv_reg, cnv_next;
  logic             done_reg, done_next;
  logic             ref_reg, ref_next;
  logic             busy_reg, busy_next;
  logic             start, active, int_pulse, smp_in, smp_take;

  // Either source may start; software selects which one counts [RQ4]
  assign start  = SW_START_SEL ? SW_START : EXT_START; // [RQ4]
  assign active = (state_reg == atsc_pkg::ST_PRE) || (state_reg == atsc_pkg::ST_ARM) ||
                  (state_reg == atsc_pkg::ST_POST);
  // Internal pacing: one pulse per SAMPLE_DIV timebase ticks [RQ1]
  assign int_pulse = TIMEBASE_TICK && (div_reg == atsc_pkg::DIV_ZERO) &&
                     (state_reg != atsc_pkg::ST_DLY);
  assign smp_in    = INT_SAMPLE_SEL ? int_pulse : EXT_SAMPLE_PULSE; // [RQ1]
  // Gated off when idle or paused [RQ10]
  assign smp_take  = smp_in && active && !PAUSE; // [RQ10]

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    div_next   = div_reg;
    dly_next   = dly_reg;
    stp_next   = 1'b0;
    smp_next   = smp_take;
    cnv_next   = 1'b0;
    done_next  = done_reg;
    ref_next   = ref_reg;
    if (INT_SAMPLE_SEL && active && TIMEBASE_TICK) begin
      if (div_reg != atsc_pkg::DIV_ZERO) begin
        div_next = div_reg - 1'b1;
      end else if (SAMPLE_DIV > 1) begin
        div_next = SAMPLE_DIV - 1'b1;
      end else begin
        // Zero would wrap to a full-range period; treat it like one
        div_next = atsc_pkg::DIV_ZERO;
      end
    end
    // Conversions only counted during a running acquisition [RQ2]
    cnv_next = CONVERSION_PULSE && active && !PAUSE; // [RQ2]
    case (state_reg)
      atsc_pkg::ST_IDLE: begin
        if (start) begin
          stp_next  = SW_START_SEL; // [RQ5]
          done_next = 1'b0;
          ref_next  = 1'b0;
          cnt_next  = PRETRIG_MODE ? PRE_COUNT : POST_COUNT; // [RQ3] [RQ6]
          div_next  = atsc_pkg::DIV_ZERO;
          dly_next  = FIRST_DELAY;
          if (INT_SAMPLE_SEL) begin
            state_next = atsc_pkg::ST_DLY; // [RQ11]
          end else begin
            state_next = PRETRIG_MODE ? atsc_pkg::ST_PRE : atsc_pkg::ST_POST;
          end
        end
      end
      atsc_pkg::ST_DLY: begin
        // Counted in timebase ticks so the delay tracks the timebase, not SAMPLE_DIV [RQ11]
        if (TIMEBASE_TICK) begin
          dly_next = dly_reg - 8'h01; // [RQ11]
          if (dly_reg <= 8'h01) begin
            state_next = PRETRIG_MODE ? atsc_pkg::ST_PRE : atsc_pkg::ST_POST;
          end
        end
      end
      atsc_pkg::ST_PRE: begin
        if (smp_take) begin
          cnt_next = cnt_reg - 1'b1; // [RQ6]
          if (cnt_reg <= 1) begin
            cnt_next   = POST_COUNT; // [RQ7]
            state_next = atsc_pkg::ST_ARM;
          end
        end
        // Early reference is dropped, no memory of it kept [RQ8]
      end
      atsc_pkg::ST_ARM: begin
        // Pretrigger buffer keeps filling while waiting
        if (ACQ_REFERENCE_TRIGGER) begin
          ref_next   = 1'b1;
          state_next = atsc_pkg::ST_POST; // [RQ8] [RQ9]
        end
      end
      atsc_pkg::ST_POST: begin
        if (smp_take) begin
          cnt_next = cnt_reg - 1'b1; // [RQ3] [RQ9]
          if (cnt_reg <= 1) begin
            cnt_next   = atsc_pkg::CNT_ZERO;
            done_next  = 1'b1; // [RQ12]
            state_next = atsc_pkg::ST_IDLE; // [RQ12]
          end
        end
      end
      default: state_next = atsc_pkg::ST_IDLE;
    endcase
    if (ABORT) begin
      state_next = atsc_pkg::ST_IDLE;
    end
    // Registered so the busy pin comes straight from a flop
    busy_next = (state_next != atsc_pkg::ST_IDLE);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= atsc_pkg::ST_IDLE;
      cnt_reg   <= atsc_pkg::CNT_ZERO;
      div_reg   <= atsc_pkg::DIV_ZERO;
      dly_reg   <= atsc_pkg::FIRST_DELAY_DEF;
      stp_reg   <= 1'b0;
      smp_reg   <= 1'b0;
      cnv_reg   <= 1'b0;
      done_reg  <= 1'b0;
      ref_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      div_reg   <= div_next;
      dly_reg   <= dly_next;
      stp_reg   <= stp_next;
      smp_reg   <= smp_next;
      cnv_reg   <= cnv_next;
      done_reg  <= done_next;
      ref_reg   <= ref_next;
      busy_reg  <= busy_next;
    end
  end

  assign ACQ_START_TRIGGER = stp_reg;
  assign SAMPLE_PULSE      = smp_reg;
  assign CONVERT_TAKEN     = cnv_reg;
  assign ACQ_BUSY          = busy_reg;
  assign ACQ_DONE          = done_reg;
  assign REF_ACCEPTED      = ref_reg;
  assign SAMPLE_COUNT      = cnt_reg;

  post_load_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ3]
    (state_reg == atsc_pkg::ST_IDLE && start && !PRETRIG_MODE && !ABORT)
      |=> cnt_reg == $past(POST_COUNT)) else $error("posttrigger count not loaded");
  pre_load_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ6]
    (state_reg == atsc_pkg::ST_IDLE && start && PRETRIG_MODE && !ABORT)
      |=> cnt_reg == $past(PRE_COUNT)) else $error("pretrigger count not loaded");
  sw_pulse_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ5]
    (state_reg == atsc_pkg::ST_IDLE && SW_START_SEL && SW_START)
      |=> ACQ_START_TRIGGER) else $error("software start pulse missing");
  ext_src_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ4]
    (state_reg == atsc_pkg::ST_IDLE && !SW_START_SEL && EXT_START && !ABORT)
      |=> ACQ_BUSY && !ACQ_START_TRIGGER) else $error("external start not taken");
  reload_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ7]
    (state_reg == atsc_pkg::ST_PRE && smp_take && cnt_reg <= 1 && !ABORT)
      |=> state_reg == atsc_pkg::ST_ARM && cnt_reg == $past(POST_COUNT))
    else $error("posttrigger reload missing");
  early_ref_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ8]
    (state_reg == atsc_pkg::ST_PRE) |=> state_reg != atsc_pkg::ST_POST)
    else $error("reference accepted too early");
  post_dec_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ9]
    (state_reg == atsc_pkg::ST_POST && smp_take && cnt_reg > 1 && !ABORT)
      |=> cnt_reg == $past(cnt_reg) - 1'b1) else $error("post count not decremented");
  gate_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ10]
    (!active || PAUSE) |=> !SAMPLE_PULSE) else $error("sample taken while gated");
  delay_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ11]
    (state_reg == atsc_pkg::ST_DLY) |=> !SAMPLE_PULSE) else $error("sample during delay");
  done_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ12]
    (state_reg == atsc_pkg::ST_POST && smp_take && cnt_reg <= 1 && !ABORT)
      |=> ACQ_DONE && !ACQ_BUSY ##1 !SAMPLE_PULSE) else $error("done not flagged");

  // Software start: pulse rises next cycle and falls the one after
  sequence sw_start_s;
    state_reg == atsc_pkg::ST_IDLE && SW_START_SEL && SW_START && !ABORT;
  endsequence
  sequence start_pulse_s;
    ACQ_START_TRIGGER ##1 !ACQ_START_TRIGGER;
  endsequence
  sw_len_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ5]
    sw_start_s |=> start_pulse_s) else $error("start pulse not one cycle");
  busy_start_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ5]
    (ACQ_BUSY && start) |=> !ACQ_START_TRIGGER) else $error("start taken while busy");

  // Delay exit hands over to pacing with the divider cleared
  sequence dly_exit_s;
    state_reg == atsc_pkg::ST_DLY && TIMEBASE_TICK && dly_reg <= 8'h01 && !ABORT;
  endsequence
  sequence int_pace_s;
    INT_SAMPLE_SEL && TIMEBASE_TICK && div_reg == atsc_pkg::DIV_ZERO && active && !PAUSE;
  endsequence
  dly_exit_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ11]
    dly_exit_s |=> (state_reg == atsc_pkg::ST_PRE || state_reg == atsc_pkg::ST_POST) &&
      div_reg == atsc_pkg::DIV_ZERO) else $error("delay exit wrong");
  int_pace_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ1]
    int_pace_s |=> SAMPLE_PULSE) else $error("internal sample missing");
  conv_take_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ2]
    (CONVERSION_PULSE && active && !PAUSE) |=> CONVERT_TAKEN) else $error("conversion lost");
  conv_gate_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ2]
    (!active || PAUSE) |=> !CONVERT_TAKEN) else $error("conversion taken while gated");
  early_ref_flag_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ8]
    (state_reg == atsc_pkg::ST_PRE && ACQ_REFERENCE_TRIGGER) |=> !REF_ACCEPTED)
    else $error("early reference flagged");
  ref_take_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ9]
    (state_reg == atsc_pkg::ST_ARM && ACQ_REFERENCE_TRIGGER && !ABORT)
      |=> REF_ACCEPTED && state_reg == atsc_pkg::ST_POST) else $error("reference not taken");
  arm_hold_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ7]
    (state_reg == atsc_pkg::ST_ARM && !ABORT) |=> $stable(SAMPLE_COUNT))
    else $error("count moved while armed");
  done_hold_a: assert property (@(posedge CLK) disable iff (!NRST) // [RQ12]
    (ACQ_DONE && !(state_reg == atsc_pkg::ST_IDLE && start)) |=> ACQ_DONE)
    else $error("done dropped early");
endmodule

// *** verification/atsc_tick_src.sv ***
`timescale 1ns/10ps
module atsc_tick_src #(
  parameter int PERIOD = 3
) (
  // Clock and timebase
  input  wire logic CLK,
  output logic      TICK
);
  int cnt = 0;
  // Free-running: the timebase does not know about acquisitions
  always @(posedge CLK) begin
    cnt  <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    TICK <= (cnt == PERIOD - 1);
  end
endmodule

// *** verification/atsc_acq_trigger_sample_counter_bench.sv ***
`timescale 1ns/10ps
module atsc_acq_trigger_sample_counter_bench;
  logic        clk = 0, nrst = 0, pre_m = 0, sw_sel = 0, int_sel = 0, tick;
  logic        ext_go = 0, sw_go = 0, ref_t = 0, pause = 0, abort = 0, smp = 0, conv = 0;
  logic [23:0] pre_n = 24'h000002, post_n = 24'h000002, cnt;
  logic [15:0] s_div = 16'h0002;
  logic [7:0]  f_dly = 8'h02;
  logic        st_trig, smp_out, conv_tk, busy, done, ref_ok;
  int          error_cnt = 0, samples_checked = 0;
  always #2 clk = ~clk;
  atsc_tick_src atsc_tick_src_inst (.CLK(clk), .TICK(tick));
  atsc_acq_trigger_sample_counter atsc_acq_trigger_sample_counter_inst (
    .CLK(clk), .NRST(nrst), .PRETRIG_MODE(pre_m), .SW_START_SEL(sw_sel),
    .INT_SAMPLE_SEL(int_sel), .PRE_COUNT(pre_n), .POST_COUNT(post_n),
    .SAMPLE_DIV(s_div), .FIRST_DELAY(f_dly), .TIMEBASE_TICK(tick), .SW_START(sw_go),
    .EXT_START(ext_go), .ACQ_REFERENCE_TRIGGER(ref_t), .PAUSE(pause), .ABORT(abort),
    .EXT_SAMPLE_PULSE(smp), .CONVERSION_PULSE(conv), .ACQ_START_TRIGGER(st_trig),
    .SAMPLE_PULSE(smp_out), .CONVERT_TAKEN(conv_tk), .ACQ_BUSY(busy), .ACQ_DONE(done),
    .REF_ACCEPTED(ref_ok), .SAMPLE_COUNT(cnt));
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cfg(input logic pm, input logic ss, input logic is, input logic [23:0] pr, po);
    @(posedge clk);
    {pre_m, sw_sel, int_sel} <= {pm, ss, is};
    pre_n <= pr;
    post_n <= po;
  endtask
  // One-cycle request; returns just after the edge that took it
  task pulse(input int k);
    @(posedge clk);
    case (k)
      0: ext_go <= 1'b1;
      1: sw_go <= 1'b1;
      2: smp <= 1'b1;
      3: ref_t <= 1'b1;
      4: conv <= 1'b1;
      default: abort <= 1'b1;
    endcase
    @(posedge clk);
    {ext_go, sw_go, smp, ref_t, conv, abort} <= 6'h00;
    #1;
  endtask
  task t_post;
    cfg(0, 0, 0, 2, 2);
    pulse(0);
    chk("busy", busy, 1);
    chk("start_out", st_trig, 0);
    chk("count", cnt, 2);
    pulse(0);
    chk("busy_start", cnt, 2);
    pulse(2);
    chk("sample", smp_out, 1);
    chk("count", cnt, 1);
    pulse(2);
    chk("done", done, 1);
    chk("busy", busy, 0);
    pulse(2);
    chk("idle_sample", smp_out, 0);
    chk("count", cnt, 0);
    $display("post test finished");
  endtask
  task t_pre;
    cfg(1, 1, 0, 2, 3);
    pulse(1);
    chk("start_out", st_trig, 1);
    chk("count", cnt, 2);
    pulse(3);
    chk("ref_early", ref_ok, 0);
    pulse(2);
    pulse(2);
    chk("reload", cnt, 3);
    pulse(3);
    chk("ref", ref_ok, 1);
    for (int i = 2; i >= 0; i--) begin
      pulse(2);
      chk("count", cnt, i);
    end
    chk("done", done, 1);
    $display("pretrigger test finished");
  endtask
  task t_pause;
    cfg(0, 0, 0, 2, 2);
    pulse(0);
    @(posedge clk) pause <= 1'b1;
    pulse(2);
    chk("paused_sample", smp_out, 0);
    chk("count", cnt, 2);
    pulse(4);
    chk("paused_conv", conv_tk, 0);
    @(posedge clk) pause <= 1'b0;
    pulse(2);
    chk("resume_sample", smp_out, 1);
    chk("resume_count", cnt, 1);
    pulse(4);
    chk("conv", conv_tk, 1);
    pulse(5);
    chk("abort_busy", busy, 0);
    chk("abort_done", done, 0);
    $display("pause test finished");
  endtask
  task t_int(input logic [7:0] d, input logic [15:0] v);
    int n, w;
    cfg(0, 0, 1, 2, 2);
    f_dly <= d;
    s_div <= v;
    pulse(0);
    for (int s = 0; s < 2; s++) begin
      n = 0;
      w = 0;
      do begin
        if (tick === 1'b1) n++;
        @(posedge clk);
        #1;
        w++;
      end while (smp_out !== 1'b1 && w < 40);
      chk("tick_gap", n, (s == 0) ? d + 1 : v);
      chk("pace_seen", smp_out, 1);
    end
    chk("done", done, 1);
    $display("internal pacing test finished");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_post;
    t_pre;
    t_pause;
    t_int(8'h02, 16'h0002);
    t_int(8'h01, 16'h0001);
    summarize;
  end
  // Tests need well under 300 cycles; this span is generous
  initial begin
    #40000;
    error_cnt++;
    summarize;
  end
endmodule
